// File: rtl/pdc_map.svh
`ifndef PDC_MAP_SVH
`define PDC_MAP_SVH
// Functional notes
// - on/off indicator register, one bit per output
// - each input pin drives its own pre-driver
// - reset: sparks ignition mode, heater general mode
// - per-channel bit selects ignition or general mode
// - pin OR bit by default, AND when selected
// - open load off only, short on only
// - open load and overcurrent flags report faults
// - drain below open-load threshold sets fault
// - drain above short threshold sets fault
// - both thresholds fixed, no register changes them
// - cleared enable switches off open-load source
// - shared shunt: single threshold, double when both on in ignition mode
// - mixed modes: shunt only to ignition channel
// - both general mode: shunt for channel one
// - heater uses its own shunt circuit
// - per-output summary fault bit while fault present
// - channels may be pulse-width modulated
// - two-bit field selects four frequency modes
// - duty in 1 percent steps, 100+ means full
// - disabled sink forces open-load flag to zero

// ----------------------------------------
// register addresses
// ----------------------------------------
`define PDC_CFG_ADDR_HEATER 4'h7
`define PDC_CFG_ADDR_SPARK_A 4'h8
`define PDC_CFG_ADDR_SPARK_B 4'h9
`define PDC_CTL_ADDR_ONOFF 4'h0
`define PDC_CTL_ADDR_DUTY_HEATER 4'h9
`define PDC_CTL_ADDR_DUTY_SPARK_A 4'hA
`define PDC_CTL_ADDR_DUTY_SPARK_B 4'hB
`define PDC_ADDR_INDICATORS 4'hE

// ----------------------------------------
// configuration fields and reset values
// ----------------------------------------
`define PDC_CFG_MODE_BIT 7
`define PDC_CFG_OL_BIT 4
`define PDC_CFG_AND_BIT 2
`define PDC_CFG_FREQ_HI 1
`define PDC_CFG_FREQ_LO 0
`define PDC_CFG_RST_HEATER 8'h10
`define PDC_CFG_RST_SPARK 8'h80
`define PDC_CTL_RST 8'h00
`define PDC_DUTY_RST 7'h00
`define PDC_IND_RST 8'h00

// ----------------------------------------
// pwm timing
// ----------------------------------------
`define PDC_DUTY_FULL 7'h64
`define PDC_PCT_LAST 7'h63
`define PDC_STEPS_PER_PERIOD 100
`define PDC_CLK_PERIOD_NS 8
`define PDC_PERIOD_100HZ_NS 10000000
`define PDC_PERIOD_1KHZ_NS 1000000
`define PDC_STEP_SLOW_CYC (`PDC_PERIOD_100HZ_NS / `PDC_STEPS_PER_PERIOD / `PDC_CLK_PERIOD_NS)
`define PDC_STEP_FAST_CYC (`PDC_PERIOD_1KHZ_NS / `PDC_STEPS_PER_PERIOD / `PDC_CLK_PERIOD_NS)
`endif

// File: rtl/pdc_pkg.sv
package pdc_pkg;
   // ----------------------------------------
   // frequency and duty source modes
   // ----------------------------------------
   typedef enum logic [1:0]
   {
      PDC_FREQ_NONE = 2'h0,
      PDC_FREQ_100HZ = 2'h1,
      PDC_FREQ_1KHZ = 2'h2,
      PDC_FREQ_EXT100 = 2'h3
   } pdc_freq_t;
endpackage : pdc_pkg

// File: rtl/pdc_pwm.sv
`timescale 1ns/10ps
`include "pdc_map.svh"
module pdc_pwm
   import pdc_pkg::*;
#(
   parameter int P_STEP_SLOW = `PDC_STEP_SLOW_CYC,
   parameter int P_STEP_FAST = `PDC_STEP_FAST_CYC
)
(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire pdc_freq_t i_mode,
   input wire logic [6:0] i_duty,
   input wire logic i_ext_pin,
   output logic o_pwm
);
   logic [15:0] pre_ff;
   logic [15:0] lim;
   logic [6:0] pct_ff;
   logic ext_d_ff;
   logic tick;

   // ----------------------------------------
   // step tick per mode
   // ----------------------------------------
   // four frequency modes
   always_comb
   begin
      lim = 16'h0000;
      tick = 1'b0;
      case (i_mode)
         PDC_FREQ_100HZ:
         begin
            lim = 16'(P_STEP_SLOW - 1);
            tick = (pre_ff == lim);
         end
         PDC_FREQ_1KHZ:
         begin
            lim = 16'(P_STEP_FAST - 1);
            tick = (pre_ff == lim);
         end
         // external edges: 100 edges make one period
         PDC_FREQ_EXT100: tick = i_ext_pin & ~ext_d_ff;
         default: tick = 1'b0;
      endcase
   end

   // prescaler, held at zero outside internal modes
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst || tick || i_mode == PDC_FREQ_NONE || i_mode == PDC_FREQ_EXT100)
         pre_ff <= 16'h0000;
      else
         pre_ff <= pre_ff + 16'h0001;
   end

   // edge memory for the external source
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         ext_d_ff <= 1'b0;
      else
         ext_d_ff <= i_ext_pin;
   end

   // percent position inside the period
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         pct_ff <= 7'h00;
      else if (tick)
         pct_ff <= (pct_ff == `PDC_PCT_LAST) ? 7'h00 : pct_ff + 7'h01;
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         o_pwm <= 1'b0;
      else
         o_pwm <= (i_duty >= `PDC_DUTY_FULL) || (pct_ff < i_duty);
   end
endmodule : pdc_pwm

// File: rtl/pdc_top.sv
`timescale 1ns/10ps
`include "pdc_map.svh"
module pdc_top
   import pdc_pkg::*;
#(
   parameter int P_STEP_SLOW = `PDC_STEP_SLOW_CYC
)
(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_spark_input_pin_a,
   input wire logic i_spark_input_pin_b,
   input wire logic i_heater_input_pin,
   input wire logic i_cfg_wr,
   input wire logic i_ctl_wr,
   input wire logic [3:0] i_reg_addr,
   input wire logic [7:0] i_reg_data,
   input wire logic [4:0] i_lowside_on,
   input wire logic i_spark_drain_sense_a_below_ol,
   input wire logic i_spark_drain_sense_b_below_ol,
   input wire logic i_heater_drain_sense_below_ol,
   input wire logic i_spark_drain_sense_a_above_sc,
   input wire logic i_spark_drain_sense_b_above_sc,
   input wire logic i_heater_drain_sense_above_sc,
   input wire logic i_spark_shunt_trip,
   input wire logic i_heater_shunt_trip,
   output logic o_spark_gate_out_a,
   output logic o_spark_gate_out_b,
   output logic o_heater_gate_out,
   output logic [7:0] o_onoff_ind,
   output logic [2:0] o_open_load_flag,
   output logic [2:0] o_overcurrent_flag,
   output logic [2:0] o_fault_sum,
   output logic [2:0] o_ol_sink_en,
   output logic o_shunt_threshold_double,
   output logic o_spark_shunt_route_a,
   output logic o_spark_shunt_route_b,
   output logic o_heater_shunt_route
);
   // channel index equals indicator bit: 0 heater, 1 spark b, 2 spark a
   logic [2:0] pin_raw;
   logic [2:0] below_ol;
   logic [2:0] above_sc;
   logic [2:0] sync1_ff;
   logic [2:0] sync2_ff;
   logic [7:0] cfg_ff [3];
   logic [7:0] ctl_ff;
   logic [6:0] duty_ff [3];
   logic [2:0] gate_ff;
   logic [2:0] pwm;
   logic [2:0] cmd;
   logic [2:0] nxt_gate;
   logic [2:0] spark_mode;
   logic [2:0] shunt_trip;
   logic [2:0] nxt_ol;
   logic [2:0] nxt_oc;
   logic nxt_route_a;
   logic nxt_route_b;
   logic [7:0] ind_ff;
   logic [2:0] ol_ff;
   logic [2:0] oc_ff;
   logic [2:0] sum_ff;
   logic [2:0] sink_ff;
   logic dbl_ff;
   logic route_a_ff;
   logic route_b_ff;
   logic route_h_ff;
   // reset images of the config words, so a single field bit can be picked
   localparam logic [7:0] CFG_RST_H = `PDC_CFG_RST_HEATER;
   localparam logic [7:0] CFG_RST_S = `PDC_CFG_RST_SPARK;

   assign pin_raw = {i_spark_input_pin_a, i_spark_input_pin_b, i_heater_input_pin};
   assign below_ol = {i_spark_drain_sense_a_below_ol, i_spark_drain_sense_b_below_ol,
                      i_heater_drain_sense_below_ol};
   assign above_sc = {i_spark_drain_sense_a_above_sc, i_spark_drain_sense_b_above_sc,
                      i_heater_drain_sense_above_sc};

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   // two-stage pin sync
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         sync1_ff <= 3'h0;
         sync2_ff <= 3'h0;
      end
      else
      begin
         sync1_ff <= pin_raw;
         sync2_ff <= sync1_ff;
      end
   end

   // ----------------------------------------
   // configuration and control registers
   // ----------------------------------------
   // reset mode defaults
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         cfg_ff[0] <= `PDC_CFG_RST_HEATER;
         cfg_ff[1] <= `PDC_CFG_RST_SPARK;
         cfg_ff[2] <= `PDC_CFG_RST_SPARK;
      end
      else if (i_cfg_wr)
      begin
         case (i_reg_addr)
            `PDC_CFG_ADDR_HEATER: cfg_ff[0] <= i_reg_data;
            `PDC_CFG_ADDR_SPARK_B: cfg_ff[1] <= i_reg_data;
            `PDC_CFG_ADDR_SPARK_A: cfg_ff[2] <= i_reg_data;
            default: cfg_ff[0] <= cfg_ff[0];
         endcase
      end
   end

   // on/off bits and duty words; unmapped addresses are ignored
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         ctl_ff <= `PDC_CTL_RST;
         duty_ff[0] <= `PDC_DUTY_RST;
         duty_ff[1] <= `PDC_DUTY_RST;
         duty_ff[2] <= `PDC_DUTY_RST;
      end
      else if (i_ctl_wr)
      begin
         case (i_reg_addr)
            `PDC_CTL_ADDR_ONOFF: ctl_ff <= i_reg_data;
            `PDC_CTL_ADDR_DUTY_HEATER: duty_ff[0] <= i_reg_data[6:0];
            `PDC_CTL_ADDR_DUTY_SPARK_B: duty_ff[1] <= i_reg_data[6:0];
            `PDC_CTL_ADDR_DUTY_SPARK_A: duty_ff[2] <= i_reg_data[6:0];
            default: ctl_ff <= ctl_ff;
         endcase
      end
   end

   // ----------------------------------------
   // per-channel command, pwm and diagnosis
   // ----------------------------------------
   assign shunt_trip = {i_spark_shunt_trip & route_a_ff, i_spark_shunt_trip & route_b_ff,
                        i_heater_shunt_trip & route_h_ff};

   for (genvar k = 0; k < 3; k++)
   begin : g_ch
      pdc_pwm #(
         .P_STEP_SLOW(P_STEP_SLOW),
         .P_STEP_FAST(`PDC_STEP_FAST_CYC)
      ) u_pwm (
         .i_ref_clk(i_ref_clk),
         .i_rst(i_rst),
         .i_mode(pdc_freq_t'(cfg_ff[k][`PDC_CFG_FREQ_HI:`PDC_CFG_FREQ_LO])),
         .i_duty(duty_ff[k]),
         .i_ext_pin(sync2_ff[k]),
         .o_pwm(pwm[k])
      );

      assign spark_mode[k] = cfg_ff[k][`PDC_CFG_MODE_BIT];

      assign cmd[k] = cfg_ff[k][`PDC_CFG_AND_BIT] ? (sync2_ff[k] & ctl_ff[k])
                                                   : (sync2_ff[k] | ctl_ff[k]);
      // without a pwm mode the command drives the gate as is
      assign nxt_gate[k] = (cfg_ff[k][`PDC_CFG_FREQ_HI:`PDC_CFG_FREQ_LO] == 2'h0) ?
                           cmd[k] : (cmd[k] & pwm[k]);

      // open load off only; below threshold; sink gate
      assign nxt_ol[k] = cfg_ff[k][`PDC_CFG_OL_BIT] & ~gate_ff[k] & below_ol[k];
      // short when on; comparator thresholds are fixed outside
      assign nxt_oc[k] = gate_ff[k] & (above_sc[k] | shunt_trip[k]);
   end

   // gate flops drive the pins directly
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         gate_ff <= 3'h0;
      else
         gate_ff <= nxt_gate;
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         ind_ff <= `PDC_IND_RST;
      else
         ind_ff <= {i_lowside_on, nxt_gate};
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         ol_ff <= 3'h0;
         oc_ff <= 3'h0;
         sum_ff <= 3'h0;
      end
      else
      begin
         ol_ff <= nxt_ol;
         oc_ff <= nxt_oc;
         sum_ff <= nxt_ol | nxt_oc;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         sink_ff <= {CFG_RST_S[`PDC_CFG_OL_BIT], CFG_RST_S[`PDC_CFG_OL_BIT],
                     CFG_RST_H[`PDC_CFG_OL_BIT]};
      else
         sink_ff <= {cfg_ff[2][`PDC_CFG_OL_BIT], cfg_ff[1][`PDC_CFG_OL_BIT],
                     cfg_ff[0][`PDC_CFG_OL_BIT]};
   end

   // ----------------------------------------
   // shared shunt routing
   // ----------------------------------------
   // mixed: ignition channel only; both general: channel a
   always_comb
   begin
      nxt_route_a = spark_mode[2] | ~spark_mode[1];
      nxt_route_b = spark_mode[1];
   end

   // threshold doubles with both on in ignition mode; heater own shunt
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         dbl_ff <= 1'b0;
         route_a_ff <= 1'b1;
         route_b_ff <= 1'b1;
         route_h_ff <= 1'b1;
      end
      else
      begin
         dbl_ff <= spark_mode[2] & spark_mode[1] & nxt_gate[2] & nxt_gate[1];
         route_a_ff <= nxt_route_a;
         route_b_ff <= nxt_route_b;
         route_h_ff <= 1'b1;
      end
   end

   assign o_spark_gate_out_a = gate_ff[2];
   assign o_spark_gate_out_b = gate_ff[1];
   assign o_heater_gate_out = gate_ff[0];
   assign o_onoff_ind = ind_ff;
   assign o_open_load_flag = ol_ff;
   assign o_overcurrent_flag = oc_ff;
   assign o_fault_sum = sum_ff;
   assign o_ol_sink_en = sink_ff;
   assign o_shunt_threshold_double = dbl_ff;
   assign o_spark_shunt_route_a = route_a_ff;
   assign o_spark_shunt_route_b = route_b_ff;
   assign o_heater_shunt_route = route_h_ff;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   // indicator tracks gates
   ind_gates_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      o_onoff_ind[2:0] == {o_spark_gate_out_a, o_spark_gate_out_b, o_heater_gate_out})
      else $error("indicator bits differ from gates");

   reset_modes_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      $fell(i_rst) |-> (!spark_mode[0] && spark_mode[1] && spark_mode[2]))
      else $error("channel modes wrong after reset");

   or_combine_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (!cfg_ff[0][`PDC_CFG_AND_BIT] && cfg_ff[0][`PDC_CFG_FREQ_HI:`PDC_CFG_FREQ_LO] == 2'h0
       && sync2_ff[0])
      |=> o_heater_gate_out)
      else $error("or combine failed to turn heater on");

   and_combine_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (cfg_ff[2][`PDC_CFG_AND_BIT] && !ctl_ff[2]) |=> !o_spark_gate_out_a)
      else $error("and combine let spark a on");

   // pin to gate in three edges
   pin_latency_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      ($rose(i_spark_input_pin_b) && cfg_ff[1] == `PDC_CFG_RST_SPARK)
      ##1 (cfg_ff[1] == `PDC_CFG_RST_SPARK) [*2] |=> o_spark_gate_out_b)
      else $error("spark b gate late after pin rise");

   ol_cause_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      o_open_load_flag[0] |-> $past(cfg_ff[0][`PDC_CFG_OL_BIT] && !gate_ff[0]
                                    && below_ol[0]))
      else $error("open load flag without cause");

   oc_on_only_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      o_overcurrent_flag[2] |-> $past(gate_ff[2]))
      else $error("overcurrent flag while off");

   ol_forced_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !cfg_ff[1][`PDC_CFG_OL_BIT] |=> !o_open_load_flag[1] && !o_ol_sink_en[1])
      else $error("open load flag with sink disabled");

   dbl_thresh_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (spark_mode[2] && spark_mode[1] && nxt_gate[2] && nxt_gate[1])
      |=> o_shunt_threshold_double)
      else $error("threshold not doubled with both on");

   gp_route_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (!spark_mode[2] && !spark_mode[1]) |=> (o_spark_shunt_route_a && !o_spark_shunt_route_b))
      else $error("shunt not given to channel a");

   fault_sum_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      o_fault_sum == (o_open_load_flag | o_overcurrent_flag))
      else $error("summary fault bit mismatch");

   dbl_seen_c: cover property (@(posedge i_ref_clk) disable iff (i_rst) o_shunt_threshold_double);
   ol_seen_c: cover property (@(posedge i_ref_clk) disable iff (i_rst) |o_open_load_flag);
   oc_seen_c: cover property (@(posedge i_ref_clk) disable iff (i_rst) |o_overcurrent_flag);
   pwm_seen_c: cover property (@(posedge i_ref_clk) disable iff (i_rst)
      cfg_ff[0][`PDC_CFG_FREQ_HI:`PDC_CFG_FREQ_LO] != 2'h0 && $fell(o_heater_gate_out));
endmodule : pdc_top

// File: testbench/pdc_stage_model.sv
`timescale 1ns/10ps
// external switches, loads and shunts behind the three gate outputs
module pdc_stage_model
(
   input wire logic [2:0] i_gate,
   input wire logic i_double,
   input wire logic [2:0] i_open,
   input wire logic [2:0] i_short,
   input wire logic [2:0] i_heavy,
   output logic [2:0] o_below_ol,
   output logic [2:0] o_above_sc,
   output logic o_spark_trip,
   output logic o_heater_trip
);
   logic [2:0] drain_high;
   logic [2:0] amps;

   // drain rests at battery when off with a load, or when shorted;
   // an on switch pulls it low, so both comparators lie outside their state
   // drain comparators
   assign drain_high = i_short | (~i_gate & ~i_open);
   assign o_below_ol = ~drain_high;
   assign o_above_sc = drain_high;

   // one unit per healthy spark channel, three when overloaded
   // shared shunt threshold
   assign amps = {1'b0, i_gate[2] & i_heavy[2], i_gate[2]}
      + {1'b0, i_gate[1] & i_heavy[1], i_gate[1]};
   assign o_spark_trip = amps > (i_double ? 3'h2 : 3'h1);
   assign o_heater_trip = i_gate[0] & i_heavy[0];
endmodule : pdc_stage_model

// File: testbench/pdc_top_tb.sv
`timescale 1ns/10ps
module pdc_top_tb;
   localparam logic [7:0] MD [0:8] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01,
                                       8'h02, 8'h02, 8'h03};
   localparam logic [7:0] DU [0:8] = '{8'h00, 8'h01, 8'h32, 8'h63, 8'h64, 8'h7F,
                                       8'h00, 8'h7F, 8'h32};
   localparam logic [7:0] EX [0:8] = '{8'h00, 8'h02, 8'h64, 8'hC6, 8'hC8, 8'hC8,
                                       8'h00, 8'hC8, 8'h64};
   logic clk, rst, cfg_wr, ctl_wr, dbl, ra, rb, rh, strip, htrip;
   logic [2:0] pin, open_q, short_q, heavy_q, gate, below, above, ocf, olf, fsum, sink, e;
   logic [3:0] addr;
   logic [7:0] data, ind, cnt;
   logic [4:0] lows;
   int bad_count, checks, n;

   // ----------------------------------------
   // design and far side
   // ----------------------------------------
   pdc_top #(.P_STEP_SLOW(2)) dut_u
   (
      .i_ref_clk(clk), .i_rst(rst), .i_spark_input_pin_a(pin[2]),
      .i_spark_input_pin_b(pin[1]), .i_heater_input_pin(pin[0]),
      .i_cfg_wr(cfg_wr), .i_ctl_wr(ctl_wr), .i_reg_addr(addr), .i_reg_data(data),
      .i_lowside_on(lows), .i_spark_drain_sense_a_below_ol(below[2]),
      .i_spark_drain_sense_b_below_ol(below[1]), .i_heater_drain_sense_below_ol(below[0]),
      .i_spark_drain_sense_a_above_sc(above[2]), .i_spark_drain_sense_b_above_sc(above[1]),
      .i_heater_drain_sense_above_sc(above[0]), .i_spark_shunt_trip(strip),
      .i_heater_shunt_trip(htrip), .o_spark_gate_out_a(gate[2]),
      .o_spark_gate_out_b(gate[1]), .o_heater_gate_out(gate[0]), .o_onoff_ind(ind),
      .o_open_load_flag(olf), .o_overcurrent_flag(ocf), .o_fault_sum(fsum),
      .o_ol_sink_en(sink), .o_shunt_threshold_double(dbl), .o_spark_shunt_route_a(ra),
      .o_spark_shunt_route_b(rb), .o_heater_shunt_route(rh)
   );

   pdc_stage_model stage_u
   (
      .i_gate(gate), .i_double(dbl), .i_open(open_q), .i_short(short_q),
      .i_heavy(heavy_q), .o_below_ol(below), .o_above_sc(above),
      .o_spark_trip(strip), .o_heater_trip(htrip)
   );

   // free-running reference clock
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk

   // sample just after the edge so the edge's updates have landed
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : tick

   task automatic wr(input logic is_cfg, input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      cfg_wr <= is_cfg;
      ctl_wr <= ~is_cfg;
      addr <= a;
      data <= d;
      @(posedge clk);
      cfg_wr <= 1'b0;
      ctl_wr <= 1'b0;
      tick(3);
   endtask : wr

   task automatic cfg3(input logic [7:0] h, input logic [7:0] a, input logic [7:0] b);
      wr(1'b1, 4'h7, h);
      wr(1'b1, 4'h8, a);
      wr(1'b1, 4'h9, b);
   endtask : cfg3

   task automatic do_reset;
      @(posedge clk);
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      tick(2);
      chk(ind, 8'h00);
      chk({5'h00, sink}, 8'h01);
      chk({5'h00, ra, rb, rh}, 8'h07);
      chk({dbl, olf, ocf, 1'b0}, 8'h00);
   endtask : do_reset

   // counts gate-high cycles of the heater over 200 cycles
   task automatic count(input logic tog, output logic [7:0] c);
      c = 8'h00;
      repeat (200)
      begin
         @(posedge clk);
         if (tog)
            pin[0] <= ~pin[0];
         #1;
         c = c + {7'h00, gate[0]};
      end
   endtask : count

   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : complete_run

   // hang guard: the whole run is far shorter than this
   initial
   begin
      repeat (100000) @(posedge clk);
      bad_count++;
      complete_run();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      rst = 1'b1;
      pin = 3'h0;
      cfg_wr = 1'b0;
      ctl_wr = 1'b0;
      addr = 4'h0;
      data = 8'h00;
      lows = 5'h00;
      open_q = 3'h0;
      short_q = 3'h0;
      heavy_q = 3'h0;
      bad_count = 0;
      checks = 0;
      do_reset();
      // pin reaches the gate on the third edge
      @(posedge clk);
      pin <= 3'h4;
      repeat (2) @(posedge clk);
      #1;
      chk({7'h00, gate[2]}, 8'h00);
      tick(1);
      chk(ind, 8'h04);
      $display("test reset and latency done");
      for (n = 0; n < 128; n++)
      begin
         if (n[5:0] == 6'h00)
            cfg3({5'h04, n[6], 2'h0}, {5'h10, n[6], 2'h0}, {5'h10, n[6], 2'h0});
         @(posedge clk);
         pin <= n[5:3];
         lows <= n[4:0];
         wr(1'b0, 4'h0, {5'h00, n[2:0]});
         e = n[6] ? (n[5:3] & n[2:0]) : (n[5:3] | n[2:0]);
         chk({5'h00, gate}, {5'h00, e});
         chk(ind, {n[4:0], e});
      end
      $display("test combine done");
      @(posedge clk);
      pin <= 3'h0;
      lows <= 5'h00;
      cfg3(8'h10, 8'h90, 8'h90);
      wr(1'b0, 4'h0, 8'h00);
      @(posedge clk);
      open_q <= 3'h7;
      tick(3);
      chk({5'h00, olf}, 8'h07);
      chk({5'h00, fsum}, 8'h07);
      wr(1'b0, 4'h0, 8'h05);
      chk({olf, fsum, 2'h0}, 8'h48);
      wr(1'b1, 4'h9, 8'h80);
      chk({5'h00, sink}, 8'h05);
      chk({olf, fsum, 2'h0}, 8'h00);
      @(posedge clk);
      open_q <= 3'h0;
      short_q <= 3'h7;
      wr(1'b0, 4'h0, 8'h00);
      chk({ocf, olf, 2'h0}, 8'h00);
      wr(1'b0, 4'h0, 8'h07);
      chk({ocf, fsum, 2'h0}, 8'hFC);
      @(posedge clk);
      short_q <= 3'h0;
      wr(1'b0, 4'h0, 8'h00);
      $display("test open load and short done");
      for (n = 0; n < 4; n++)
      begin
         cfg3(8'h10, {n[1], 7'h00}, {n[0], 7'h00});
         e = {n[1] | ~n[0], n[0], 1'b1};
         chk({5'h00, ra, rb, rh}, {5'h00, e});
         wr(1'b0, 4'h0, 8'h06);
         chk({7'h00, dbl}, {7'h00, n == 3});
         chk({5'h00, ocf}, {5'h00, e[2:1] & {2{n != 3}}, 1'b0});
         @(posedge clk);
         heavy_q <= 3'h3;
         wr(1'b0, 4'h0, 8'h03);
         chk({5'h00, ocf}, {6'h00, n[0], 1'b1});
         @(posedge clk);
         heavy_q <= 3'h0;
      end
      $display("test shunt routing done");
      wr(1'b0, 4'h0, 8'h01);
      for (n = 0; n < 9; n++)
      begin
         wr(1'b1, 4'h7, 8'h10 | MD[n]);
         wr(1'b0, 4'h9, DU[n]);
         count(MD[n] == 8'h03, cnt);
         count(MD[n] == 8'h03, cnt);
         chk(cnt, EX[n]);
      end
      $display("test pulse width done");
      @(posedge clk);
      pin <= 3'h0;
      wr(1'b1, 4'h7, 8'h10);
      wr(1'b0, 4'h0, 8'h00);
      wr(1'b1, 4'hF, 8'h00);
      wr(1'b0, 4'hE, 8'hFF);
      chk({sink, gate, 2'h0}, 8'h20);
      wr(1'b1, 4'h8, 8'h10);
      do_reset();
      $display("test unmapped and second reset done");
      complete_run();
   end
endmodule : pdc_top_tb
